// ### src/pdo_params.svh
`ifndef PDO_PARAMS_SVH
`define PDO_PARAMS_SVH

// Register byte offsets, decoded on the low address bits
`define PDO_ADDR_W 8
`define PDO_OFF_DATA 8'h00
`define PDO_OFF_DIR 8'h04
`define PDO_OFF_PIN 8'h08
`define PDO_OFF_CTRL 8'h0c
`define PDO_OFF_PCMSK 8'h10

// Control register fields
`define PDO_CTRL_PUD_BIT 0
`define PDO_CTRL_PIN_CHANGE_GROUP3_ENABLE_BIT 1
`define PDO_CTRL_SLEEP_BIT 2

// Reset values
`define PDO_RST_DATA 8'h00
`define PDO_RST_DIR 8'h00
`define PDO_RST_CTRL 3'h0
`define PDO_RST_PCMSK 8'h00

// Port width and bus answer
`define PDO_PINS 8
`define PDO_RESP_OKAY 1'h0

`endif

// ### src/pdo_pkg.sv
package pdo_pkg;

  // Override set for one pin
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic input_en_override_en;
    logic input_en_override_val;
  } pdo_ovr_s;

  // Enables and outputs coming from the peripherals
  typedef struct packed {
    logic timer2_compare_a_en;
    logic timer2_compare_a_out;
    logic timer2_compare_b_en;
    logic timer2_compare_b_out;
    logic timer1_compare_a_en;
    logic timer1_compare_a_out;
    logic timer1_compare_b_en;
    logic timer1_compare_b_out;
    logic serial1_tx_enable;
    logic serial1_tx_line;
    logic serial1_rx_enable;
    logic serial0_tx_enable;
    logic serial0_tx_line;
    logic serial0_rx_enable;
    logic ext_irq_zero_en;
    logic ext_irq_one_en;
  } pdo_periph_s;

  // Pin inputs delivered to the peripherals
  typedef struct packed {
    logic timer1_capture_in;
    logic serial1_rx_line;
    logic serial0_rx_line;
    logic ext_irq_zero;
    logic ext_irq_one;
    logic [7:0] pin_change_src;
  } pdo_taps_s;

endpackage

// ### src/pdo_pin_mux.sv
`timescale 1ns/100ps
`include "pdo_params.svh"

module pdo_pin_mux
  import pdo_pkg::*;
(
  input wire pdo_ovr_s ovr,
  input wire logic port_data,
  input wire logic port_dir,
  input wire logic global_pullup_disable,
  input wire logic sleep_off,
  input wire logic pin_sync,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup,
  output logic din
);

  logic pu_base;
  logic die;

  // Pull-up only for an input with its data bit set
  assign pu_base = ~port_dir & port_data;
  // Global disable sits last so no override can revive a pull-up
  assign pad_pullup = (ovr.pullup_override_en ? ovr.pullup_override_val
                       : pu_base) & ~global_pullup_disable;
  assign pad_oe = ovr.dir_override_en ? ovr.dir_override_val
                  : port_dir;
  assign pad_out = ovr.outval_override_en ? ovr.outval_override_val
                   : port_data;
  assign die = ovr.input_en_override_en ? ovr.input_en_override_val
               : ~sleep_off;
  assign din = pin_sync & die;

endmodule

// ### src/pdo_port_d.sv
`timescale 1ns/100ps
`include "pdo_params.svh"

// Contract
// - Timer2 compare A enabled drives pin 7's value, direction and pull-up stay with the port bits.
// - Timer2 compare B enabled drives pin 6's value, which leaves the pin only when its direction bit is one.
// - Timer1 compare A enabled drives pin 5's value, with direction left to the port direction bit.
// - Timer1 compare B enabled drives pin 4's value, with direction left to the port direction bit.
// - Pin 6's synchronized input feeds the timer1 capture trigger as well as its pin-change source.
// - Serial 1 transmitter enabled forces pin 3 to output with the transmit line and pull-up off.
// - Serial 0 transmitter enabled forces pin 1 to output with the transmit line and pull-up off.
// - Serial 1 receiver enabled forces pin 2 to input with pull-up from its data bit unless globally disabled.
// - Serial 0 receiver enabled forces pin 0 to input, feeds the receiver, pull-up from data unless disabled.
// - A set mask bit with group 3 enabled forces that pin's input on and feeds pin-change sources 24 to 31.
// - External interrupt 1 enabled forces pin 3's input on and feeds that interrupt.
// - External interrupt 0 enabled forces pin 2's input on and feeds that interrupt.
// - The global pull-up disable turns off every pull-up of the port.
module pdo_port_d
  import pdo_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire pdo_periph_s periph,
  output pdo_taps_s taps,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup
);

  localparam int PINS = `PDO_PINS;

  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic [7:0] dir_r;
  logic [7:0] dir_nxt;
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic [7:0] pcmsk_r;
  logic [7:0] pcmsk_nxt;
  logic [7:0] pin_sync_r;
  logic [7:0] din;
  logic wr_pend_r;
  logic [`PDO_ADDR_W-1:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic addr_ok;
  logic global_pullup_disable;
  logic pin_change_group3_enable;
  logic sleep_off;
  pdo_ovr_s ovr [PINS];

  assign global_pullup_disable = ctrl_r[`PDO_CTRL_PUD_BIT];
  assign pin_change_group3_enable = ctrl_r[`PDO_CTRL_PIN_CHANGE_GROUP3_ENABLE_BIT];
  assign sleep_off = ctrl_r[`PDO_CTRL_SLEEP_BIT];

  // Read word for an address, narrow registers in the low bits
  function automatic logic [31:0] rd_word(
    input logic [`PDO_ADDR_W-1:0] a,
    input logic [7:0] d,
    input logic [7:0] r,
    input logic [2:0] c,
    input logic [7:0] m,
    input logic [7:0] p
  );
    logic [31:0] w;
    w = 32'h0;
    if (a == `PDO_OFF_DATA) begin
      w[7:0] = d;
    end else if (a == `PDO_OFF_DIR) begin
      w[7:0] = r;
    end else if (a == `PDO_OFF_PIN) begin
      w[7:0] = p;
    end else if (a == `PDO_OFF_CTRL) begin
      w[2:0] = c;
    end else if (a == `PDO_OFF_PCMSK) begin
      w[7:0] = m;
    end
    return w;
  endfunction

  // Zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = `PDO_RESP_OKAY;
  assign hrdata = hrdata_r;
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[`PDO_ADDR_W-1:0];
      end
    end
  end

  // Pending data-phase write, so a read right behind it sees the new value
  always_comb begin
    data_nxt = data_r;
    dir_nxt = dir_r;
    ctrl_nxt = ctrl_r;
    pcmsk_nxt = pcmsk_r;
    if (wr_pend_r) begin
      if (wr_addr_r == `PDO_OFF_DATA) begin
        data_nxt = hwdata[7:0];
      end else if (wr_addr_r == `PDO_OFF_DIR) begin
        dir_nxt = hwdata[7:0];
      end else if (wr_addr_r == `PDO_OFF_CTRL) begin
        ctrl_nxt = hwdata[2:0];
      end else if (wr_addr_r == `PDO_OFF_PCMSK) begin
        pcmsk_nxt = hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_r <= `PDO_RST_DATA;
      dir_r <= `PDO_RST_DIR;
      ctrl_r <= `PDO_RST_CTRL;
      pcmsk_r <= `PDO_RST_PCMSK;
    end else begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      ctrl_r <= ctrl_nxt;
      pcmsk_r <= pcmsk_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_r <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= rd_word(haddr[`PDO_ADDR_W-1:0], data_nxt, dir_nxt,
                          ctrl_nxt, pcmsk_nxt, din);
    end
  end

  // One stage of sampling; pins are synchronous to clk here
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_sync_r <= 8'h00;
    end else begin
      pin_sync_r <= pad_in;
    end
  end

  // Override table for the eight pins
  always_comb begin
    for (int k = 0; k < PINS; k++) begin
      ovr[k] = '0;
      ovr[k].input_en_override_val = 1'b1;
      ovr[k].input_en_override_en = pcmsk_r[k] & pin_change_group3_enable;
    end
    // Compare outputs replace only the value
    ovr[7].outval_override_en = periph.timer2_compare_a_en;
    ovr[7].outval_override_val = periph.timer2_compare_a_out;
    ovr[6].outval_override_en = periph.timer2_compare_b_en;
    ovr[6].outval_override_val = periph.timer2_compare_b_out;
    ovr[5].outval_override_en = periph.timer1_compare_a_en;
    ovr[5].outval_override_val = periph.timer1_compare_a_out;
    ovr[4].outval_override_en = periph.timer1_compare_b_en;
    ovr[4].outval_override_val = periph.timer1_compare_b_out;
    // Transmitters own direction, value and pull-up
    ovr[3].pullup_override_en = periph.serial1_tx_enable;
    ovr[3].dir_override_en = periph.serial1_tx_enable;
    ovr[3].dir_override_val = 1'b1;
    ovr[3].outval_override_en = periph.serial1_tx_enable;
    ovr[3].outval_override_val = periph.serial1_tx_line;
    ovr[1].pullup_override_en = periph.serial0_tx_enable;
    ovr[1].dir_override_en = periph.serial0_tx_enable;
    ovr[1].dir_override_val = 1'b1;
    ovr[1].outval_override_en = periph.serial0_tx_enable;
    ovr[1].outval_override_val = periph.serial0_tx_line;
    // Receivers force input, pull-up still from the data bit
    ovr[2].pullup_override_en = periph.serial1_rx_enable;
    ovr[2].pullup_override_val = data_r[2] & ~global_pullup_disable;
    ovr[2].dir_override_en = periph.serial1_rx_enable;
    ovr[0].pullup_override_en = periph.serial0_rx_enable;
    ovr[0].pullup_override_val = data_r[0] & ~global_pullup_disable;
    ovr[0].dir_override_en = periph.serial0_rx_enable;
    // External interrupts need the input awake even in sleep
    ovr[3].input_en_override_en = ovr[3].input_en_override_en
                                  | periph.ext_irq_one_en;
    ovr[2].input_en_override_en = ovr[2].input_en_override_en
                                  | periph.ext_irq_zero_en;
  end

  for (genvar g = 0; g < PINS; g++) begin : g_pin
    pdo_pin_mux u_mux (
      .ovr(ovr[g]),
      .port_data(data_r[g]),
      .port_dir(dir_r[g]),
      .global_pullup_disable(global_pullup_disable),
      .sleep_off(sleep_off),
      .pin_sync(pin_sync_r[g]),
      .pad_out(pad_out[g]),
      .pad_oe(pad_oe[g]),
      .pad_pullup(pad_pullup[g]),
      .din(din[g])
    );
  end

  assign taps.timer1_capture_in = din[6];
  assign taps.serial1_rx_line = din[2];
  assign taps.serial0_rx_line = din[0];
  assign taps.ext_irq_zero = din[2];
  assign taps.ext_irq_one = din[3];
  assign taps.pin_change_src = din;

  property p_t2a_pin7;
    @(posedge clk) disable iff (srst)
      periph.timer2_compare_a_en |->
        pad_out[7] == periph.timer2_compare_a_out && pad_oe[7] == dir_r[7];
  endproperty
  a_t2a_pin7: assert property (p_t2a_pin7)
    else $error("pin 7 not driven by timer2 compare A");

  property p_t2b_pin6;
    @(posedge clk) disable iff (srst)
      periph.timer2_compare_b_en && !dir_r[6] |->
        !pad_oe[6] && pad_out[6] == periph.timer2_compare_b_out;
  endproperty
  a_t2b_pin6: assert property (p_t2b_pin6)
    else $error("pin 6 compare B value or direction wrong");

  property p_t1a_pin5;
    @(posedge clk) disable iff (srst)
      periph.timer1_compare_a_en |->
        pad_out[5] == periph.timer1_compare_a_out && pad_oe[5] == dir_r[5];
  endproperty
  a_t1a_pin5: assert property (p_t1a_pin5)
    else $error("pin 5 not driven by timer1 compare A");

  property p_t1b_pin4;
    @(posedge clk) disable iff (srst)
      periph.timer1_compare_b_en |->
        pad_out[4] == periph.timer1_compare_b_out && pad_oe[4] == dir_r[4];
  endproperty
  a_t1b_pin4: assert property (p_t1b_pin4)
    else $error("pin 4 not driven by timer1 compare B");

  property p_capture_in;
    @(posedge clk) disable iff (srst)
      !$past(srst) && !sleep_off |->
        taps.timer1_capture_in == $past(pad_in[6]);
  endproperty
  a_capture_in: assert property (p_capture_in)
    else $error("capture input does not follow pin 6");

  property p_tx1_pin3;
    @(posedge clk) disable iff (srst)
      periph.serial1_tx_enable |->
        pad_oe[3] && !pad_pullup[3] && pad_out[3] == periph.serial1_tx_line;
  endproperty
  a_tx1_pin3: assert property (p_tx1_pin3)
    else $error("pin 3 not owned by serial 1 transmitter");

  property p_tx0_pin1;
    @(posedge clk) disable iff (srst)
      periph.serial0_tx_enable |->
        pad_oe[1] && !pad_pullup[1] && pad_out[1] == periph.serial0_tx_line;
  endproperty
  a_tx0_pin1: assert property (p_tx0_pin1)
    else $error("pin 1 not owned by serial 0 transmitter");

  property p_rx1_pin2;
    @(posedge clk) disable iff (srst)
      periph.serial1_rx_enable |->
        !pad_oe[2] && pad_pullup[2] == (data_r[2] && !global_pullup_disable);
  endproperty
  a_rx1_pin2: assert property (p_rx1_pin2)
    else $error("pin 2 not input for serial 1 receiver");

  property p_rx0_pin0;
    @(posedge clk) disable iff (srst)
      periph.serial0_rx_enable && !$past(srst) && !sleep_off |->
        !pad_oe[0] && taps.serial0_rx_line == $past(pad_in[0]);
  endproperty
  a_rx0_pin0: assert property (p_rx0_pin0)
    else $error("pin 0 not fed to serial 0 receiver");

  property p_pc_wake;
    @(posedge clk) disable iff (srst)
      pin_change_group3_enable && pcmsk_r[7] && sleep_off && !$past(srst) |->
        taps.pin_change_src[7] == $past(pad_in[7]);
  endproperty
  a_pc_wake: assert property (p_pc_wake)
    else $error("pin change source 31 gated while enabled");

  property p_irq1_wake;
    @(posedge clk) disable iff (srst)
      periph.ext_irq_one_en && sleep_off && !$past(srst) |->
        taps.ext_irq_one == $past(pad_in[3]);
  endproperty
  a_irq1_wake: assert property (p_irq1_wake)
    else $error("external interrupt 1 input gated");

  property p_irq0_wake;
    @(posedge clk) disable iff (srst)
      periph.ext_irq_zero_en && sleep_off && !$past(srst) |->
        taps.ext_irq_zero == $past(pad_in[2]);
  endproperty
  a_irq0_wake: assert property (p_irq0_wake)
    else $error("external interrupt 0 input gated");

  property p_pud_all;
    @(posedge clk) disable iff (srst)
      global_pullup_disable |-> pad_pullup == 8'h00;
  endproperty
  a_pud_all: assert property (p_pud_all)
    else $error("pull-up on while globally disabled");

  property p_plain_port;
    @(posedge clk) disable iff (srst)
      !periph.serial0_tx_enable && !periph.serial0_rx_enable |->
        pad_oe[1:0] == dir_r[1:0]
        && pad_pullup[1] == (!dir_r[1] && data_r[1] && !global_pullup_disable);
  endproperty
  a_plain_port: assert property (p_plain_port)
    else $error("pins 1:0 not under port bits");

endmodule

// ### dv/pdo_far_model.sv
`timescale 1ns/100ps
module pdo_far_model
  import pdo_pkg::*;
(
  input wire logic clk,
  input wire logic ld,
  input wire pdo_periph_s ld_val,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  output pdo_periph_s periph,
  output logic [7:0] pad_in
);
  logic [7:0] last_r;
  initial periph = '0;
  initial last_r = 8'h00;
  // Peripheral levels move only at an edge
  always @(posedge clk) begin
    if (ld) periph <= ld_val;
  end
  // Own driver first, then outside driver, then pull-up
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pad_in[k] = pad_oe[k] ? pad_out[k] : ext_en[k] ? ext[k] :
        pad_pullup[k] ? 1'b1 : ~last_r[k];
    end
  end
  // Floating pin shows the inverse of its last level, never a kind 0
  always @(posedge clk) begin
    for (int k = 0; k < 8; k++) begin
      if (pad_oe[k] | ext_en[k] | pad_pullup[k]) last_r[k] <= pad_in[k];
    end
  end
endmodule

// ### dv/port_d_alt_function_override_tb_top.sv
`timescale 1ns/100ps
`include "pdo_params.svh"
module port_d_alt_function_override_tb_top
  import pdo_pkg::*;
;
  logic clk, srst, hsel, hwrite, hreadyout, hresp, ld;
  logic [31:0] haddr, hwdata, hrdata, r, s;
  logic [1:0] htrans;
  logic [2:0] hsize, ctl;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, ext_en, ext;
  logic [7:0] dat, dir, msk;
  pdo_periph_s periph, ld_val, pv;
  pdo_taps_s taps;
  int seed, err_count, comparisons, cyc;

  pdo_port_d pdo_port_d_i (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .periph(periph), .taps(taps),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup));
  pdo_far_model pdo_far_model_i (.clk(clk), .ld(ld), .ld_val(ld_val),
    .ext_en(ext_en), .ext(ext), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .periph(periph), .pad_in(pad_in));

  always #5 clk = ~clk;

  function automatic logic [7:0] x_oe(logic [7:0] dr, pdo_periph_s p);
    x_oe = dr;
    if (p.serial1_tx_enable) x_oe[3] = 1'b1;
    if (p.serial0_tx_enable) x_oe[1] = 1'b1;
    if (p.serial1_rx_enable) x_oe[2] = 1'b0;
    if (p.serial0_rx_enable) x_oe[0] = 1'b0;
  endfunction

  function automatic logic [7:0] x_out(logic [7:0] d, pdo_periph_s p);
    x_out = d;
    if (p.timer2_compare_a_en) x_out[7] = p.timer2_compare_a_out;
    if (p.timer2_compare_b_en) x_out[6] = p.timer2_compare_b_out;
    if (p.timer1_compare_a_en) x_out[5] = p.timer1_compare_a_out;
    if (p.timer1_compare_b_en) x_out[4] = p.timer1_compare_b_out;
    if (p.serial1_tx_enable) x_out[3] = p.serial1_tx_line;
    if (p.serial0_tx_enable) x_out[1] = p.serial0_tx_line;
  endfunction

  function automatic logic [7:0] x_pu(logic [7:0] d, dr, logic global_pullup_disable,
      pdo_periph_s p);
    x_pu = d & ~dr;
    if (p.serial1_tx_enable) x_pu[3] = 1'b0;
    if (p.serial0_tx_enable) x_pu[1] = 1'b0;
    if (p.serial1_rx_enable) x_pu[2] = d[2];
    if (p.serial0_rx_enable) x_pu[0] = d[0];
    if (global_pullup_disable) x_pu = 8'h00;
  endfunction

  function automatic logic [7:0] x_ie(logic [7:0] m, logic [2:0] c,
      pdo_periph_s p);
    x_ie = {8{~c[2]}} | (m & {8{c[1]}});
    if (p.ext_irq_one_en) x_ie[3] = 1'b1;
    if (p.ext_irq_zero_en) x_ie[2] = 1'b1;
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Whole run needs about 1400 cycles
    if (cyc == 6000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end

  task automatic cmp8(logic [7:0] got, logic [7:0] exp, string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp32(logic [31:0] got, logic [31:0] exp, string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    // No local limit: a stuck slave is caught by the cycle ceiling
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    cmp8({7'h0, hresp}, {7'h0, `PDO_RESP_OKAY}, "resp");
  endtask

  task automatic check_regs();
    logic [31:0] q;
    ahb(0, `PDO_OFF_DATA, 0, q);
    cmp32(q, {24'h0, dat}, "data");
    ahb(0, `PDO_OFF_DIR, 0, q);
    cmp32(q, {24'h0, dir}, "dir");
    ahb(0, `PDO_OFF_CTRL, 0, q);
    cmp32(q, {29'h0, ctl}, "ctrl");
    ahb(0, `PDO_OFF_PCMSK, 0, q);
    cmp32(q, {24'h0, msk}, "pcmsk");
  endtask

  task automatic check_pins();
    logic [7:0] pin;
    logic [31:0] q;
    pin = pad_in & x_ie(msk, ctl, pv);
    cmp8(pad_oe, x_oe(dir, pv), "oe");
    cmp8(pad_out, x_out(dat, pv), "out");
    cmp8(pad_pullup, x_pu(dat, dir, ctl[0], pv), "pu");
    cmp8(taps.pin_change_src, pin, "pcint");
    cmp8({7'h0, taps.timer1_capture_in}, {7'h0, pin[6]}, "icp");
    cmp8({6'h0, taps.serial1_rx_line, taps.serial0_rx_line},
      {6'h0, pin[2], pin[0]}, "rx");
    cmp8({6'h0, taps.ext_irq_one, taps.ext_irq_zero},
      {6'h0, pin[3], pin[2]}, "irq");
    ahb(0, `PDO_OFF_PIN, 0, q);
    cmp32(q, {24'h0, pin}, "pin");
  endtask

  task automatic apply(pdo_periph_s p, logic [7:0] d, dr, logic [2:0] c,
      logic [7:0] m, ee, ev);
    logic [31:0] q;
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= p;
    ext_en <= ee;
    ext <= ev;
    @(posedge clk);
    ld <= 1'b0;
    pv = p;
    dat = d;
    dir = dr;
    ctl = c;
    msk = m;
    ahb(1, `PDO_OFF_DATA, {24'h0, d}, q);
    ahb(1, `PDO_OFF_DIR, {24'h0, dr}, q);
    ahb(1, `PDO_OFF_CTRL, {29'h0, c}, q);
    ahb(1, `PDO_OFF_PCMSK, {24'h0, m}, q);
    // Two edges let the pin sample flop catch the settled level
    repeat (2) @(posedge clk);
    #1;
    check_pins();
  endtask

  initial begin
    clk = 0; srst = 1; hsel = 1; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; ld = 0; ld_val = '0; ext_en = 0; ext = 0;
    dat = 0; dir = 0; ctl = 0; msk = 0; pv = '0;
    seed = 32'h149d; err_count = 0; comparisons = 0; cyc = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check_regs();
    $display("test reset done");
    apply(16'hffff, 8'hff, 8'h00, 3'h0, 8'hff, 8'h00, 8'h00);
    apply(16'hffff, 8'hff, 8'h00, 3'h1, 8'hff, 8'h00, 8'h00);
    apply(16'h0000, 8'h5a, 8'hff, 3'h4, 8'h00, 8'h00, 8'h00);
    apply(16'h0003, 8'h00, 8'h00, 3'h4, 8'h00, 8'hff, 8'h4c);
    $display("test corners done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      s = $random(seed);
      apply(r[15:0], r[23:16], r[31:24], s[2:0], s[15:8], s[23:16],
        s[31:24]);
      check_regs();
    end
    $display("test random done");
    // Read-only and unmapped places must not move anything
    ahb(1, `PDO_OFF_PIN, 32'hff, r);
    ahb(1, 32'h14, 32'hffffffff, r);
    ahb(0, 32'h14, 0, r);
    cmp32(r, 32'h0, "unmapped");
    // Deselected transfer must leave the data register alone
    hsel <= 1'b0;
    ahb(1, `PDO_OFF_DATA, {24'h0, ~dat}, r);
    hsel <= 1'b1;
    check_regs();
    check_pins();
    $display("test map done");
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    dat = 0; dir = 0; ctl = 0; msk = 0;
    check_regs();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
